/* rtl/ebu_defs.svh */
`ifndef EBU_DEFS_SVH
`define EBU_DEFS_SVH

// Field and bus widths.
`define EBU_CNT_W    4
`define EBU_IDX_W    6
`define EBU_ADDR_W   32
`define EBU_DATA_W   16
`define EBU_BE_W     2

// Strobe slots in the per-strobe arrays and edge-select vectors.
`define EBU_STB_CS   0
`define EBU_STB_WE   1
`define EBU_STB_OE   2
`define EBU_STB_BE   3
`define EBU_STB_LBA  4
`define EBU_STB_N    5

// Reset and idle values, and the cycle index cap.
`define EBU_STROBE_IDLE 1'h1
`define EBU_IDX_ZERO    6'h00
`define EBU_IDX_MAX     6'h3F

`endif

/* rtl/ebu_pkg.sv */
`include "ebu_defs.svh"

package ebu_pkg;

   // Access sequencer states.
   typedef enum logic [1:0] {
      ebu_idle = 2'b00,
      ebu_arm  = 2'b01,
      ebu_run  = 2'b10
   } ebu_state_type;

   // Bus clock cycle index within an access.
   typedef logic [`EBU_IDX_W-1:0] ebu_index_type;

endpackage

/* rtl/ebu_sync.sv */
`timescale 1ns/1ns
`include "ebu_defs.svh"

module ebu_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         reset,
   // Raw pins and filtered view.
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   genvar i;

   for (i = 0; i < W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;

      // Three-stage capture; a change counts once stages two and three agree.
      always_ff @(posedge clk) begin
         if (reset) begin
            s1       <= 1'h0;
            s2       <= 1'h0;
            s3       <= 1'h0;
            level[i] <= 1'h0;
            rise[i]  <= 1'h0;
            fall[i]  <= 1'h0;
         end else begin
            s1       <= pin[i];
            s2       <= s1;
            s3       <= s2;
            rise[i]  <= (s2 == s3) && s3 && !level[i];
            fall[i]  <= (s2 == s3) && !s3 && level[i];
            if (s2 == s3) begin
               level[i] <= s3;
            end
         end
      end
   end

endmodule

/* rtl/ebu_strobe.sv */
`timescale 1ns/1ns
`include "ebu_defs.svh"

module ebu_strobe
   import ebu_pkg::*;
(
   // Clock and reset.
   input  wire logic          clk,
   input  wire logic          reset,
   // Access progress.
   input  wire logic          active,
   input  wire logic          enable,
   input  wire logic          bclk_rise,
   input  wire logic          bclk_fall,
   input  wire ebu_index_type rise_index,
   input  wire ebu_index_type fall_index,
   // Placement of this strobe.
   input  wire ebu_index_type assert_at,
   input  wire ebu_index_type negate_at,
   input  wire logic          assert_on_fall,
   input  wire logic          negate_on_fall,
   // Active-low strobe.
   output logic               strobe_n
);

   logic hit_assert;
   logic hit_negate;

   // Each edge of the strobe picks the rising or falling bus clock edge.
   assign hit_assert = assert_on_fall ? (bclk_fall && fall_index == assert_at)
                                      : (bclk_rise && rise_index == assert_at);
   assign hit_negate = negate_on_fall ? (bclk_fall && fall_index == negate_at)
                                      : (bclk_rise && rise_index == negate_at);

   // Negation is taken only while asserted, so an assert and negate on one edge leave the strobe asserted.
   always_ff @(posedge clk) begin
      if (reset || !active) begin
         strobe_n <= `EBU_STROBE_IDLE;
      end else if (!strobe_n && hit_negate) begin
         strobe_n <= 1'h1;
      end else if (strobe_n && enable && hit_assert) begin
         strobe_n <= 1'h0;
      end
   end

endmodule

/* rtl/ebu_external_bus_unit.sv */
`timescale 1ns/1ns
`include "ebu_defs.svh"

// Notes on behaviour
// - Each strobe edge picks rising or falling.
// - New address always starts on falling edge.
// - Muxed address phase ends on selected edge.
// - Write data starts rising; muxed mode selectable.
// - Inputs sampled on rising bus clock only.
// - Only fast clock enable option set works.
// - Address leads chip select assertion.
// - Plain address held until chip select negates.
// - Muxed address removed after latch counts plus one.
// - Write enable follows chip select by delay.
// - Write enable negates ahead of chip select.
// - Plain read enable follows chip select.
// - Muxed read enable adds latch, hold, one.
// - Read enable negates ahead of chip select.
// - Read byte enables follow chip select.
// - Read byte enables negate ahead of select.
// - Latch strobe follows chip select by delay.
// - All placement counts are whole bus cycles.

module ebu_external_bus_unit
   import ebu_pkg::*;
(
   // Clock and reset.
   input  wire logic                    clk,
   input  wire logic                    reset,
   // Access request and answer.
   input  wire logic                    access_start,
   input  wire logic                    access_write,
   input  wire logic                    access_mux,
   input  wire logic                    access_burst,
   input  wire logic [`EBU_ADDR_W-1:0]  access_address,
   input  wire logic [`EBU_DATA_W-1:0]  access_wdata,
   input  wire logic [`EBU_BE_W-1:0]    access_bytes,
   output logic                         access_busy,
   output logic                         access_done,
   output logic                         access_refused,
   output logic [`EBU_DATA_W-1:0]       read_data,
   output logic                         read_valid,
   // Configuration.
   input  wire logic                    fast_clock_enable_option,
   input  wire logic                    dtack_enable,
   input  wire ebu_index_type           access_length,
   input  wire logic [`EBU_CNT_W-1:0]   select_assert_delay,
   input  wire logic [`EBU_CNT_W-1:0]   select_negate_lead,
   input  wire logic [`EBU_CNT_W-1:0]   write_strobe_assert_delay,
   input  wire logic [`EBU_CNT_W-1:0]   write_strobe_negate_lead,
   input  wire logic [`EBU_CNT_W-1:0]   read_strobe_assert_delay,
   input  wire logic [`EBU_CNT_W-1:0]   read_strobe_negate_lead,
   input  wire logic [`EBU_CNT_W-1:0]   read_byte_strobe_assert_delay,
   input  wire logic [`EBU_CNT_W-1:0]   read_byte_strobe_negate_lead,
   input  wire logic [`EBU_CNT_W-1:0]   latch_strobe_assert_delay,
   input  wire logic [`EBU_CNT_W-1:0]   latch_strobe_negate_count,
   input  wire logic [`EBU_CNT_W-1:0]   read_latch_assert_delay,
   input  wire logic [`EBU_CNT_W-1:0]   read_latch_negate_count,
   input  wire logic [`EBU_CNT_W-1:0]   address_hold_count,
   input  wire logic [`EBU_STB_N-1:0]   assert_on_fall,
   input  wire logic [`EBU_STB_N-1:0]   negate_on_fall,
   input  wire logic                    address_end_on_fall,
   input  wire logic                    write_data_on_fall,
   // Memory bus pins.
   input  wire logic                    bus_clock,
   input  wire logic [`EBU_DATA_W-1:0]  data_in,
   input  wire logic                    transfer_ack_n,
   input  wire logic                    burst_clock_enable_in_n,
   output logic                         chip_select_n,
   output logic [`EBU_ADDR_W-1:0]       address,
   output logic                         address_oe,
   output logic                         write_enable_n,
   output logic                         output_enable_n,
   output logic [`EBU_BE_W-1:0]         byte_enable_n,
   output logic                         address_latch_strobe_n,
   output logic [`EBU_DATA_W-1:0]       data_out,
   output logic                         data_oe
);

   ebu_state_type                 state;
   ebu_index_type                 cycle;
   ebu_index_type                 rise_index;
   ebu_index_type                 fall_index;
   ebu_index_type                 addr_end_at;
   logic                          bclk_rise;
   logic                          bclk_fall;
   logic [`EBU_DATA_W-1:0]        data_level;
   logic                          ack_n_level;
   logic                          ecb_n_level;
   logic                          write_q;
   logic                          mux_q;
   logic                          burst_q;
   logic [`EBU_BE_W-1:0]          bytes_q;
   logic                          last_rise;
   logic                          ack_ok;
   logic                          addr_end_hit;
   logic                          wdata_hit;
   ebu_index_type                 assert_at [`EBU_STB_N];
   ebu_index_type                 negate_at [`EBU_STB_N];
   logic [`EBU_STB_N-1:0]         stb_enable;
   logic [`EBU_STB_N-1:0]         stb_n;

   // Widens a configuration count to a cycle index.
   function automatic ebu_index_type widen(input logic [`EBU_CNT_W-1:0] c);
      return `EBU_IDX_W'(c);
   endfunction

   // True on the chosen bus clock edge of the given cycle.
   function automatic logic edge_hit(input logic on_fall, input logic r, input logic f,
                                     input ebu_index_type ri, input ebu_index_type fi,
                                     input ebu_index_type at);
      return on_fall ? (f && fi == at) : (r && ri == at);
   endfunction

   // Bus clock edge finder on the system clock.
   ebu_sync #(.W(1)) u_bclk_sync (
      .clk   (clk),
      .reset (reset),
      .pin   (bus_clock),
      .level (),
      .rise  (bclk_rise),
      .fall  (bclk_fall)
   );

   // Read data, acknowledge and burst clock enable capture.
   ebu_sync #(.W(`EBU_DATA_W + 2)) u_in_sync (
      .clk   (clk),
      .reset (reset),
      .pin   ({burst_clock_enable_in_n, transfer_ack_n, data_in}),
      .level ({ecb_n_level, ack_n_level, data_level}),
      .rise  (),
      .fall  ()
   );

   // Cycle indices: rise k opens cycle k, fall k sits in its middle.
   assign rise_index = (state == ebu_arm) ? `EBU_IDX_ZERO : cycle + 6'h01;
   assign fall_index = cycle;
   assign ack_ok     = !dtack_enable || !ack_n_level;
   assign last_rise  = (state == ebu_run) && bclk_rise && rise_index >= access_length;
   assign access_busy = (state != ebu_idle);

   // Muxed address phase ends latch assert plus latch negate plus one cycles in.
   assign addr_end_at = widen(latch_strobe_negate_count) + widen(latch_strobe_assert_delay) + 6'h01;
   assign addr_end_hit = edge_hit(address_end_on_fall, bclk_rise, bclk_fall,
                                  rise_index, fall_index, addr_end_at);
   assign wdata_hit = mux_q ? edge_hit(write_data_on_fall, bclk_rise, bclk_fall,
                                       rise_index, fall_index, addr_end_at)
                            : (state == ebu_arm && bclk_rise && address_oe);

   // Access sequencer.
   always_ff @(posedge clk) begin
      if (reset) begin
         state          <= ebu_idle;
         cycle          <= `EBU_IDX_ZERO;
         access_done    <= 1'h0;
         access_refused <= 1'h0;
      end else begin
         access_done    <= 1'h0;
         access_refused <= 1'h0;
         unique case (state)
            ebu_idle: begin
               if (access_start && fast_clock_enable_option) begin
                  state <= ebu_arm;
               end else if (access_start) begin
                  access_refused <= 1'h1;
               end
            end
            ebu_arm: begin
               if (bclk_rise && address_oe) begin
                  state <= ebu_run;
                  cycle <= `EBU_IDX_ZERO;
               end
            end
            ebu_run: begin
               if (last_rise && ack_ok) begin
                  state       <= ebu_idle;
                  access_done <= 1'h1;
               end else if (bclk_rise && cycle != `EBU_IDX_MAX) begin
                  cycle <= cycle + 6'h01;
               end
            end
         endcase
      end
   end

   // Request fields held for the whole access.
   always_ff @(posedge clk) begin
      if (reset) begin
         write_q  <= 1'h0;
         mux_q    <= 1'h0;
         burst_q  <= 1'h0;
         bytes_q  <= 2'h0;
         address  <= 32'h00000000;
         data_out <= 16'h0000;
      end else if (state == ebu_idle && access_start && fast_clock_enable_option) begin
         write_q  <= access_write;
         mux_q    <= access_mux;
         burst_q  <= access_burst;
         bytes_q  <= access_bytes;
         address  <= access_address;
         data_out <= access_wdata;
      end
   end

   // Address drive starts on the first falling edge and ends per mode.
   always_ff @(posedge clk) begin
      if (reset || state == ebu_idle) begin
         address_oe <= 1'h0;
      end else if (state == ebu_arm && bclk_fall) begin
         address_oe <= 1'h1;
      end else if (state == ebu_run && mux_q && addr_end_hit) begin
         address_oe <= 1'h0;
      end
   end

   // Write data drive holds until the access ends.
   always_ff @(posedge clk) begin
      if (reset || state == ebu_idle) begin
         data_oe <= 1'h0;
      end else if (write_q && !data_oe && wdata_hit) begin
         data_oe <= 1'h1;
      end
   end

   // Read capture on rising bus clock edges only.
   always_ff @(posedge clk) begin
      if (reset) begin
         read_data  <= 16'h0000;
         read_valid <= 1'h0;
      end else begin
         read_valid <= 1'h0;
         if (state == ebu_run && bclk_rise && !write_q) begin
            if (burst_q ? (!ecb_n_level && !output_enable_n) : (last_rise && ack_ok)) begin
               read_data  <= data_level;
               read_valid <= 1'h1;
            end
         end
      end
   end

   // Strobe placement in absolute cycles from the access start.
   always_comb begin
      assert_at[`EBU_STB_CS]  = widen(select_assert_delay);
      negate_at[`EBU_STB_CS]  = access_length - widen(select_negate_lead);
      assert_at[`EBU_STB_WE]  = widen(write_strobe_assert_delay);
      negate_at[`EBU_STB_WE]  = access_length - widen(write_strobe_negate_lead);
      assert_at[`EBU_STB_OE]  = mux_q ? widen(read_strobe_assert_delay) + widen(read_latch_negate_count)
                                        + widen(read_latch_assert_delay) + widen(address_hold_count) + 6'h01
                                      : widen(read_strobe_assert_delay);
      negate_at[`EBU_STB_OE]  = access_length - widen(read_strobe_negate_lead);
      assert_at[`EBU_STB_BE]  = write_q ? widen(select_assert_delay)
                                        : widen(read_byte_strobe_assert_delay);
      negate_at[`EBU_STB_BE]  = access_length - (write_q ? widen(select_negate_lead)
                                                         : widen(read_byte_strobe_negate_lead));
      assert_at[`EBU_STB_LBA] = widen(latch_strobe_assert_delay);
      negate_at[`EBU_STB_LBA] = widen(latch_strobe_assert_delay) + widen(latch_strobe_negate_count);
      stb_enable              = {mux_q, 1'h1, !write_q, write_q, 1'h1};
   end

   genvar s;

   // One sequenced strobe per control output.
   for (s = 0; s < `EBU_STB_N; s++) begin : g_strobe
      ebu_strobe u_strobe (
         .clk            (clk),
         .reset          (reset),
         .active         (state == ebu_run),
         .enable         (stb_enable[s]),
         .bclk_rise      (bclk_rise),
         .bclk_fall      (bclk_fall),
         .rise_index     (rise_index),
         .fall_index     (fall_index),
         .assert_at      (assert_at[s]),
         .negate_at      (negate_at[s]),
         .assert_on_fall (assert_on_fall[s]),
         .negate_on_fall (negate_on_fall[s]),
         .strobe_n       (stb_n[s])
      );
   end

   // Strobe outputs; byte lanes follow the request mask.
   assign chip_select_n          = stb_n[`EBU_STB_CS];
   assign write_enable_n         = stb_n[`EBU_STB_WE];
   assign output_enable_n        = stb_n[`EBU_STB_OE];
   assign address_latch_strobe_n = stb_n[`EBU_STB_LBA];
   assign byte_enable_n          = stb_n[`EBU_STB_BE] ? 2'h3 : ~bytes_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence done_s;
      access_done;
   endsequence
   sequence strobes_idle_s;
      chip_select_n && write_enable_n && output_enable_n && address_latch_strobe_n;
   endsequence

   addr_fall_start_a: assert property ($rose(address_oe) |-> $past(bclk_fall))
      else $error("Address drive began off a falling edge.");
   mux_addr_end_a: assert property (mux_q && $fell(address_oe) && $past(state == ebu_run)
      |-> $past(fall_index == addr_end_at || rise_index == addr_end_at))
      else $error("Muxed address ended at the wrong cycle.");
   wdata_rise_a: assert property ($rose(data_oe) && !mux_q |-> $past(bclk_rise))
      else $error("Plain write data did not start on a rising edge.");
   sample_rise_a: assert property (read_valid |-> $past(bclk_rise) && !write_q)
      else $error("Read data captured away from a rising edge.");
   refuse_no_fce_a: assert property (access_start && state == ebu_idle && !fast_clock_enable_option
      |=> state == ebu_idle && access_refused)
      else $error("Access accepted without the fast clock enable option.");
   addr_lead_cs_a: assert property (!mux_q && !chip_select_n |-> address_oe)
      else $error("Chip select active without a valid address.");
   addr_hold_cs_a: assert property (!mux_q && $rose(chip_select_n) && state == ebu_run |-> address_oe)
      else $error("Address dropped before chip select negated.");
   cs_assert_time_a: assert property ($fell(chip_select_n)
      |-> $past(edge_hit(assert_on_fall[`EBU_STB_CS], bclk_rise, bclk_fall, rise_index, fall_index,
                         widen(select_assert_delay))))
      else $error("Chip select asserted at the wrong cycle.");

   we_assert_time_a: assert property ($fell(write_enable_n) |-> $past(write_q)
      && $past(rise_index == widen(write_strobe_assert_delay)
               || fall_index == widen(write_strobe_assert_delay)))
      else $error("Write enable asserted at the wrong cycle.");

   oe_plain_time_a: assert property ($fell(output_enable_n) && !mux_q |-> !write_q
      && $past(rise_index == widen(read_strobe_assert_delay)
               || fall_index == widen(read_strobe_assert_delay)))
      else $error("Read enable asserted at the wrong cycle.");

   lba_time_a: assert property ($fell(address_latch_strobe_n) |-> mux_q
      && $past(rise_index == assert_at[`EBU_STB_LBA] || fall_index == assert_at[`EBU_STB_LBA]))
      else $error("Latch strobe asserted at the wrong cycle.");

   done_release_a: assert property (done_s |=> strobes_idle_s and (!address_oe && !data_oe))
      else $error("Strobes still active after the access ended.");

endmodule

/* dv/ebu_memory_model.sv */
`timescale 1ns/1ns
`include "ebu_defs.svh"

module ebu_memory_model (
   // Bus clock and strobes from the controller.
   input  wire logic                   bus_clock,
   input  wire logic                   chip_select_n,
   input  wire logic                   write_enable_n,
   input  wire logic                   output_enable_n,
   input  wire logic [`EBU_ADDR_W-1:0] address,
   input  wire logic [`EBU_DATA_W-1:0] data_out,
   // Answers to the controller.
   output logic      [`EBU_DATA_W-1:0] data_in,
   output logic                        transfer_ack_n,
   output logic                        burst_clock_enable_in_n
);
   logic [`EBU_DATA_W-1:0] mem [0:15];
   logic [3:0]             addr_q;
   logic                   driving = 1'b0;
   // The word address is taken as select falls, since it leads select.
   always @(negedge chip_select_n) addr_q = address[3:0];
   // Write data is stored as write enable releases inside the access.
   always @(posedge write_enable_n) if (!chip_select_n) mem[addr_q] = data_out;
   // Read data starts with output enable and is held to the bus fall after deselect.
   always @(negedge output_enable_n) if (!chip_select_n) driving = 1'b1;
   always @(negedge bus_clock) if (chip_select_n) driving = 1'b0;
   // A released bus shows the inverse so stale data is never mistaken for a read.
   assign data_in = driving ? mem[addr_q] : ~mem[addr_q];
   assign transfer_ack_n = chip_select_n;
   assign burst_clock_enable_in_n = 1'h1;
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ns
`include "ebu_defs.svh"

module testbench;
   import ebu_pkg::*;
   // Clocks, request and configuration.
   logic clk = 0, reset = 1, bus_clock = 0, access_start = 0, access_write = 0, access_mux = 0;
   logic [`EBU_ADDR_W-1:0] access_address = 32'h00000005;
   logic [`EBU_DATA_W-1:0] access_wdata = 16'hA5C3, data_in, data_out, read_data, rd_seen;
   logic [`EBU_BE_W-1:0] access_bytes = 2'h3, byte_enable_n;
   logic fast_clock_enable_option = 1, transfer_ack_n, burst_clock_enable_in_n;
   ebu_index_type access_length = 6'h0C;
   logic [`EBU_CNT_W-1:0] select_assert_delay = 4'h1, select_negate_lead = 4'h1;
   logic [`EBU_CNT_W-1:0] write_strobe_assert_delay = 4'h3, write_strobe_negate_lead = 4'h2;
   logic [`EBU_CNT_W-1:0] read_strobe_assert_delay = 4'h2, read_strobe_negate_lead = 4'h1;
   logic [`EBU_CNT_W-1:0] read_byte_strobe_assert_delay = 4'h2, read_byte_strobe_negate_lead = 4'h1;
   logic [`EBU_CNT_W-1:0] latch_strobe_assert_delay = 4'h2, latch_strobe_negate_count = 4'h2;
   logic [`EBU_CNT_W-1:0] read_latch_assert_delay = 4'h1, read_latch_negate_count = 4'h1;
   logic [`EBU_CNT_W-1:0] address_hold_count = 4'h1;
   logic [`EBU_STB_N-1:0] assert_on_fall = 5'h00, negate_on_fall = 5'h00;
   logic access_busy, access_done, access_refused, read_valid, chip_select_n, address_oe;
   logic write_enable_n, output_enable_n, address_latch_strobe_n, data_oe, refused_seen, address_end_on_fall = 1'b0;
   logic [`EBU_ADDR_W-1:0] address;
   time t_cs0, t_cs1, t_we0, t_we1, t_oe0, t_oe1, t_be0, t_be1, t_lb0, t_aoe0, t_aoe1, t_doe0;
   int fail_count = 0, n_compared = 0;

   // System clock at 125 MHz and an unrelated bus clock of 80 ns.
   always #4 clk = ~clk;
   initial #3 forever #40 bus_clock = ~bus_clock;

   ebu_external_bus_unit ebu_external_bus_unit_inst (
      .clk, .reset, .access_start, .access_write, .access_mux, .access_burst(1'h0),
      .access_address, .access_wdata, .access_bytes, .access_busy, .access_done, .access_refused,
      .read_data, .read_valid, .fast_clock_enable_option, .dtack_enable(1'h0), .access_length,
      .select_assert_delay, .select_negate_lead, .write_strobe_assert_delay, .write_strobe_negate_lead,
      .read_strobe_assert_delay, .read_strobe_negate_lead, .read_byte_strobe_assert_delay,
      .read_byte_strobe_negate_lead, .latch_strobe_assert_delay, .latch_strobe_negate_count,
      .read_latch_assert_delay, .read_latch_negate_count, .address_hold_count, .assert_on_fall,
      .negate_on_fall, .address_end_on_fall, .write_data_on_fall(1'h0), .bus_clock,
      .data_in, .transfer_ack_n, .burst_clock_enable_in_n, .chip_select_n, .address, .address_oe,
      .write_enable_n, .output_enable_n, .byte_enable_n, .address_latch_strobe_n, .data_out, .data_oe);

   ebu_memory_model ebu_memory_model_inst (
      .bus_clock, .chip_select_n, .write_enable_n, .output_enable_n, .address, .data_out,
      .data_in, .transfer_ack_n, .burst_clock_enable_in_n);

   // Edge time stamps of every strobe, taken where the pins change.
   always @(negedge chip_select_n) t_cs0 = $time;
   always @(posedge chip_select_n) t_cs1 = $time;
   always @(negedge write_enable_n) t_we0 = $time;
   always @(posedge write_enable_n) t_we1 = $time;
   always @(negedge output_enable_n) t_oe0 = $time;
   always @(posedge output_enable_n) t_oe1 = $time;
   always @(negedge byte_enable_n[0]) t_be0 = $time;
   always @(posedge byte_enable_n[0]) t_be1 = $time;
   always @(negedge address_latch_strobe_n) t_lb0 = $time;
   always @(posedge address_oe) t_aoe0 = $time;
   always @(negedge address_oe) t_aoe1 = $time;
   always @(posedge data_oe) t_doe0 = $time;
   // Captured read words and refusals are held for the scenario to judge.
   always @(posedge clk) begin
      if (read_valid === 1'b1) rd_seen <= read_data;
      if (access_refused === 1'b1) refused_seen <= 1'b1;
   end

   // Compares one measured figure with its expected value.
   task automatic check(input string name, input longint exp, input longint got);
      n_compared++;
      if (exp != got) begin
         fail_count++;
         $display("mismatch %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   // Issues one access and waits a bounded time for it to complete.
   task automatic run(input logic wr, input logic mux);
      int n;
      @(negedge clk);
      {t_cs0, t_cs1, t_we0, t_we1, t_oe0, t_oe1, t_be0, t_be1, t_lb0, t_aoe0, t_aoe1, t_doe0} = '0;
      access_write = wr;
      access_mux = mux;
      access_start = 1'b1;
      @(negedge clk);
      access_start = 1'b0;
      for (n = 0; n < 400 && access_done !== 1'b1 && access_busy === 1'b1; n++) @(negedge clk);
      if (n == 400) check("access end", 0, 1);
      repeat (25) @(negedge clk);
   endtask

   // A start with the fast option cleared must be refused.
   task automatic refuse_test();
      fast_clock_enable_option = 1'b0;
      refused_seen = 1'b0;
      run(1'b1, 1'b0);
      check("refused", 1, refused_seen === 1'b1);
      fast_clock_enable_option = 1'b1;
   endtask

   // Plain write with chip select on a rising or falling bus edge.
   task automatic write_test(input int cs_fall);
      assert_on_fall = cs_fall ? 5'h01 : 5'h00;
      negate_on_fall = assert_on_fall;
      run(1'b1, 1'b0);
      check("address lead", 120 + 40 * cs_fall, t_cs0 - t_aoe0);
      check("data drive", 80 + 40 * cs_fall, t_cs0 - t_doe0);
      check("write assert", 160 - 40 * cs_fall, t_we0 - t_cs0);
      check("write lead", 80 + 40 * cs_fall, t_cs1 - t_we1);
      check("select span", 800, t_cs1 - t_cs0);
      check("address hold", 1, t_aoe1 >= t_cs1);
      assert_on_fall = 5'h00;
      negate_on_fall = 5'h00;
   endtask

   // Plain read back of the written word.
   task automatic read_test();
      select_negate_lead = 4'h0;
      rd_seen = 16'h0000;
      run(1'b0, 1'b0);
      check("read enable assert", 80, t_oe0 - t_cs0);
      check("read enable lead", 80, t_cs1 - t_oe1);
      check("byte assert", 80, t_be0 - t_cs0);
      check("byte lead", 80, t_cs1 - t_be1);
      check("read word", 1, rd_seen === 16'hA5C3);
      select_negate_lead = 4'h1;
   endtask

   // Multiplexed read: latch strobe, address phase end and delayed output enable.
   task automatic mux_read_test(input int end_fall);
      select_negate_lead = 4'h0;
      address_end_on_fall = end_fall[0];
      rd_seen = 16'h0000;
      run(1'b0, 1'b1);
      check("latch assert", 80, t_lb0 - t_cs0);
      check("address end", 320 + 40 * end_fall, t_aoe1 - t_cs0);
      check("mux read enable", 400, t_oe0 - t_cs0);
      check("mux read word", 1, rd_seen === 16'hA5C3);
      select_negate_lead = 4'h1;
      address_end_on_fall = 1'b0;
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence after a two-cycle reset.
   initial begin
      repeat (2) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      refuse_test();
      write_test(0);
      read_test();
      mux_read_test(0);
      mux_read_test(1);
      write_test(1);
      finish_test();
   end

   // Cuts a hang short well past the expected run length.
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
endmodule
